// ### cfd_pkg.sv
// package: constants and types for the channel fault diagnosis latches
package cfd_pkg;
   localparam int NUM_CH = 8;
   localparam int FRAME_BITS = 8;
   localparam int SYS_CLK_MHZ = 200;
   localparam int OL_DELAY_MIN_US = 100;
   localparam int OL_DELAY_MAX_US = 250;
   localparam int OL_DELAY_CYC = OL_DELAY_MIN_US * SYS_CLK_MHZ;
   localparam int OVL_OFF_MAX_US = 60;
   localparam int OVL_OFF_CYC = OVL_OFF_MAX_US * SYS_CLK_MHZ;
   localparam logic [1:0] DIAG_FLAGS_CH_0_1 = 2'h0;
   localparam logic [1:0] DIAG_FLAGS_CH_2_3 = 2'h1;
   localparam logic [1:0] DIAG_FLAGS_CH_4_5 = 2'h2;
   localparam logic [1:0] DIAG_FLAGS_CH_6_7 = 2'h3;
   localparam logic [2:0] CTRL_DIAG_CUR_LO = 3'h4;
   localparam logic [2:0] CTRL_DIAG_CUR_HI = 3'h5;
   localparam logic [2:0] CTRL_CMD = 3'h6;
   localparam int BIT_PROT_EVEN = 0;
   localparam int BIT_OL_EVEN = 1;
   localparam int BIT_PROT_ODD = 2;
   localparam int BIT_OL_ODD = 3;
   localparam int BIT_CLR_PROT = 0;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] DIAG_CUR_RST = 8'h00;

   typedef struct packed {
      logic       write;
      logic [2:0] addr;
      logic [3:0] data;
   } cfd_cmd_t;

   typedef struct packed {
      logic [NUM_CH-1:0] over_load;
      logic [NUM_CH-1:0] over_temp;
      logic [NUM_CH-1:0] open_load;
   } cfd_sense_t;
endpackage : cfd_pkg

// ### cfd_diag.sv
// module: fault latches, open-load timers, serial frame front end
`timescale 1ns/100ps
module cfd_diag
   import cfd_pkg::*;
#(
   parameter int OL_CYC  = cfd_pkg::OL_DELAY_CYC,
   parameter int OVL_CYC = cfd_pkg::OVL_OFF_CYC
) (
   input  wire logic                 SYS_CLK,
   input  wire logic                 RST_N,
   input  wire logic                 SCLK,
   input  wire logic                 CS_N,
   input  wire logic                 SI,
   output logic                      SO,
   output logic                      SO_OE,
   input  wire logic [NUM_CH-1:0]    CH_REQ_ON,
   input  wire cfd_pkg::cfd_sense_t  SENSE,
   output logic [NUM_CH-1:0]         CH_ON,
   output logic [NUM_CH-1:0]         DIAG_CUR_EN,
   output logic [NUM_CH-1:0]         PROT_FLAGS,
   output logic [NUM_CH-1:0]         OL_FLAGS
);
   import cfd_pkg::*;

   // ---------------- link domain (SCLK) ----------------
   logic [7:0] sh_r;
   logic [7:0] out_r;
   logic [2:0] cnt_r;
   logic       any_r;
   logic       frm_tog_r;
   logic [7:0] frm_word_r;
   logic       frm_ok_r;
   logic       so_r;
   logic [7:0] tx_word;

   // shift in on falling edge, msb first
   always_ff @(negedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         cnt_r <= 3'h0;
         any_r <= 1'b0;
         sh_r  <= 8'h00;
      end else begin
         sh_r  <= {sh_r[6:0], SI};
         cnt_r <= cnt_r + 3'h1;
         any_r <= 1'b1;
      end
   end

   // capture frame at chip-select release, toggle starts known so the sync sees no false frame
   always_ff @(posedge CS_N or negedge RST_N) begin
      if (!RST_N) begin
         frm_word_r <= 8'h00;
         frm_ok_r   <= 1'b0;
         frm_tog_r  <= 1'b0;
      end else begin
         frm_word_r <= sh_r;
         frm_ok_r   <= any_r && (cnt_r == 3'h0);
         frm_tog_r  <= ~frm_tog_r;
      end
   end

   // shift out on rising edge
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         so_r  <= 1'b0;
         out_r <= 8'h00;
      end else if (!any_r) begin
         so_r  <= tx_word[6];
         out_r <= {tx_word[5:0], 2'b00};
      end else begin
         so_r  <= out_r[7];
         out_r <= {out_r[6:0], 1'b0};
      end
   end

   // ---------------- system domain ----------------
   logic [2:0]        tog_sync_r;
   logic [NUM_CH-1:0] prot_r;
   logic [NUM_CH-1:0] ol_r;
   logic [NUM_CH-1:0] dcur_r;
   logic [NUM_CH-1:0] on_r;
   logic              clr_prot_r;
   logic              rd_pend_r;
   logic [3:0]        rd_word_r;
   logic [1:0]        rd_ptr_r;
   logic [7:0]        tx_r;
   logic              ter_r;
   logic [NUM_CH-1:0] ol_s1_r, ol_s2_r, ot_s1_r, ot_s2_r, ov_s1_r, ov_s2_r;
   logic [1:0]        cs_sync_r;
   logic              so_oe_r;
   logic              so_o_r;

   wire       frame_evt = tog_sync_r[2] ^ tog_sync_r[1];
   cfd_cmd_t  cmd;
   assign cmd = frm_word_r;
   wire       frame_ok  = frame_evt && frm_ok_r;
   wire       is_write  = frame_ok && cmd.write;
   wire       is_read   = frame_ok && !cmd.write && cmd.data[1] == 1'b0;
   wire       rd_diag   = is_read && cmd.data[0];
   wire       clr_wr    = is_write && cmd.addr == CTRL_CMD && cmd.data[BIT_CLR_PROT];

   function automatic logic [3:0] diag_reg(input logic [1:0] ptr,
                                           input logic [NUM_CH-1:0] p,
                                           input logic [NUM_CH-1:0] o);
      // protect bits 2 and 0, open-load bits 3 and 1
      diag_reg = {o[2*ptr+1], p[2*ptr+1], o[2*ptr], p[2*ptr]};
   endfunction : diag_reg

   wire [NUM_CH-1:0] ol_rd_clr = rd_diag ? (2'b11 << {cmd.addr[1:0], 1'b0}) : '0;

   always_ff @(posedge SYS_CLK) begin
      tog_sync_r <= {tog_sync_r[1:0], frm_tog_r};
      ol_s1_r    <= SENSE.open_load;
      ol_s2_r    <= ol_s1_r;
      ot_s1_r    <= SENSE.over_temp;
      ot_s2_r    <= ot_s1_r;
      ov_s1_r    <= SENSE.over_load;
      ov_s2_r    <= ov_s1_r;
      cs_sync_r  <= {cs_sync_r[0], CS_N};
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         dcur_r     <= DIAG_CUR_RST;
         clr_prot_r <= 1'b0;
         rd_pend_r  <= 1'b0;
         rd_ptr_r   <= 2'h0;
         rd_word_r  <= 4'h0;
         ter_r      <= 1'b1;
      end else if (frame_evt) begin
         ter_r <= !frm_ok_r;
         if (is_write && cmd.addr == CTRL_DIAG_CUR_LO)
            dcur_r[3:0] <= cmd.data;
         if (is_write && cmd.addr == CTRL_DIAG_CUR_HI)
            dcur_r[7:4] <= cmd.data;
         // self clear on next valid frame
         if (clr_wr)
            clr_prot_r <= 1'b1;
         else if (frame_ok)
            clr_prot_r <= 1'b0;
         rd_pend_r <= rd_diag;
         rd_ptr_r  <= cmd.addr[1:0];
         rd_word_r <= diag_reg(cmd.addr[1:0], prot_r, ol_r);
      end
   end

   // answer word for next frame
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N)
         tx_r <= 8'h00;
      else if (cs_sync_r[1])
         tx_r <= rd_pend_r ? {ter_r, 3'b010 | {1'b0, rd_ptr_r}, rd_word_r}
                           : {ter_r, 3'b000, |prot_r[7:6] | |ol_r[7:6], |prot_r[5:4] | |ol_r[5:4],
                              |prot_r[3:2] | |ol_r[3:2], |prot_r[1:0] | |ol_r[1:0]};
   end
   assign tx_word = tx_r;

   // per-channel timers
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic [$clog2(OL_CYC+1)-1:0]  ol_cnt_r;
         logic [$clog2(OVL_CYC+1)-1:0] ovl_cnt_r;
         always_ff @(posedge SYS_CLK) begin
            if (!RST_N) begin
               ol_cnt_r  <= '0;
               ovl_cnt_r <= '0;
               prot_r[g] <= FLAGS_RST[g];
               ol_r[g]   <= FLAGS_RST[g];
               on_r[g]   <= 1'b0;
            end else begin
               if (on_r[g] || !ol_s2_r[g])
                  ol_cnt_r <= '0;
               else if (ol_cnt_r != OL_CYC[$clog2(OL_CYC+1)-1:0])
                  ol_cnt_r <= ol_cnt_r + 1'b1;
               // set after delay, set wins over read clear, untouched by clear cmd
               if (!on_r[g] && ol_cnt_r == OL_CYC[$clog2(OL_CYC+1)-1:0] - 1'b1)
                  ol_r[g] <= 1'b1;
               else if (ol_rd_clr[g])
                  ol_r[g] <= 1'b0;
               if (!on_r[g] || !ov_s2_r[g])
                  ovl_cnt_r <= '0;
               else
                  ovl_cnt_r <= ovl_cnt_r + 1'b1;
               // latch protection, set wins over clear
               if (ot_s2_r[g] || (on_r[g] && ovl_cnt_r == OVL_CYC[$clog2(OVL_CYC+1)-1:0] - 1'b1))
                  prot_r[g] <= 1'b1;
               else if (clr_prot_r)
                  prot_r[g] <= 1'b0;
               on_r[g] <= CH_REQ_ON[g] && !prot_r[g] && !ot_s2_r[g]
                          && !(ovl_cnt_r == OVL_CYC[$clog2(OVL_CYC+1)-1:0] - 1'b1);
            end
         end
      end
   endgenerate

   // registered outputs
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         so_oe_r <= 1'b0;
         so_o_r  <= 1'b0;
      end else begin
         so_oe_r <= !cs_sync_r[1];
         so_o_r  <= so_r | (ter_r & !CS_N & !any_r);
      end
   end

   assign SO          = so_o_r;
   assign SO_OE       = so_oe_r;
   assign CH_ON       = on_r;
   assign DIAG_CUR_EN = dcur_r;
   assign PROT_FLAGS  = prot_r;
   assign OL_FLAGS    = ol_r;
endmodule : cfd_diag

// ### cfd_diag_asserts.sv
// port-level checks for the diagnosis block
`timescale 1ns/100ps
module cfd_diag_chk
#(
   parameter int OVL_CYC = cfd_pkg::OVL_OFF_CYC
) (
   input wire logic                SYS_CLK,
   input wire logic                RST_N,
   input wire logic                CS_N,
   input wire logic                SO_OE,
   input wire cfd_pkg::cfd_sense_t SENSE,
   input wire logic [7:0]          CH_ON,
   input wire logic [7:0]          DIAG_CUR_EN,
   input wire logic [7:0]          PROT_FLAGS,
   input wire logic [7:0]          OL_FLAGS
);
   import cfd_pkg::*;
   logic [7:0]  idle_r;
   logic [15:0] ovl_r;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // cycles since the frame select was last low, and cycles on while overloaded
   always_ff @(posedge SYS_CLK) begin
      idle_r <= !RST_N ? 8'hff : !CS_N ? 8'h00 : idle_r + {7'h0, idle_r != 8'hff};
      ovl_r  <= (RST_N && |(SENSE.over_load & CH_ON)) ? ovl_r + 16'h1 : 16'h0;
   end
   a_prot_forces_off: assert property (|(PROT_FLAGS & CH_ON) |=> !(|(PROT_FLAGS & CH_ON)))
      else $error("channel stays on with protect flag");
   a_prot_clear_frame: assert property (|($past(PROT_FLAGS) & ~PROT_FLAGS) |-> idle_r < 8'h08)
      else $error("protect flag cleared without a frame");
   a_ol_clear_frame: assert property (|($past(OL_FLAGS) & ~OL_FLAGS) |-> idle_r < 8'h08)
      else $error("open-load flag cleared without a frame");
   a_dcur_frame: assert property (!$stable(DIAG_CUR_EN) |-> idle_r < 8'h08)
      else $error("diag current changed without a frame");
   a_ol_off_only: assert property ((OL_FLAGS & ~$past(OL_FLAGS) & CH_ON & $past(CH_ON, 4)) == 8'h00)
      else $error("open-load flag set on an on channel");
   a_ol_cause: assert property ((OL_FLAGS & ~$past(OL_FLAGS) & ~$past(SENSE.open_load, 8)) == 8'h00)
      else $error("open-load flag set too early");
   a_ovl_bound: assert property (ovl_r <= 16'(OVL_CYC + 8))
      else $error("overloaded channel not switched off in time");
   a_so_release: assert property ($rose(CS_N) |-> ##[1:6] !SO_OE)
      else $error("serial out still driven after frame");
   c_ol_set: cover property ($rose(OL_FLAGS[5]));
   c_prot_clear: cover property ($fell(PROT_FLAGS[3]));
   c_ovl_off: cover property ($fell(CH_ON[0]));
endmodule : cfd_diag_chk
bind cfd_diag cfd_diag_chk #(.OVL_CYC(OVL_CYC)) u_chk (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CS_N(CS_N), .SO_OE(SO_OE), .SENSE(SENSE), .CH_ON(CH_ON),
   .DIAG_CUR_EN(DIAG_CUR_EN), .PROT_FLAGS(PROT_FLAGS), .OL_FLAGS(OL_FLAGS));

// ### cfd_host.sv
// host-side serial master model for the diagnosis block
`timescale 1ns/100ps
module cfd_host (
   input  wire logic SO,
   output logic SCLK,
   output logic CS_N,
   output logic SI
);
   logic [7:0] rx;
   initial begin
      rx = 8'h00;
      SCLK = 1'b0;
      CS_N = 1'b1;
      SI = 1'b0;
   end
   // one frame per call, msb first
   task automatic xfer(input logic [7:0] b, input int n);
      CS_N = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         #6 SI = b[i];
         rx = {rx[6:0], SO};
         SCLK = 1'b1;
         #6 SCLK = 1'b0;
      end
      #6 CS_N = 1'b1;
      SI = ~SI;
      #30;
   endtask : xfer
endmodule : cfd_host

// ### test_channel_fault_diagnosis_latches.sv
// self-checking bench for the channel fault diagnosis latches
`timescale 1ns/100ps
module test_channel_fault_diagnosis_latches;
   import cfd_pkg::*;
   logic       SYS_CLK, RST_N, SCLK, CS_N, SI, SO, SO_OE;
   logic [7:0] CH_REQ_ON, CH_ON, DIAG_CUR_EN, PROT_FLAGS, OL_FLAGS;
   cfd_sense_t SENSE;
   int         n_mismatch, check_count, cyc;
   cfd_host host (.SO(SO), .SCLK(SCLK), .CS_N(CS_N), .SI(SI));
   cfd_diag #(.OL_CYC(20), .OVL_CYC(10)) uut (
      .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE),
      .CH_REQ_ON(CH_REQ_ON), .SENSE(SENSE), .CH_ON(CH_ON), .DIAG_CUR_EN(DIAG_CUR_EN),
      .PROT_FLAGS(PROT_FLAGS), .OL_FLAGS(OL_FLAGS));
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done;
      end
   end
   task automatic w(input int n);
      repeat (n) @(negedge SYS_CLK);
   endtask : w
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic frame(input logic [7:0] b, input int n);
      host.xfer(b, n);
      w(2);
   endtask : frame
   task automatic heat;
      SENSE.over_temp[3] = 1'b1;
      w(10);
      SENSE.over_temp[3] = 1'b0;
      w(5);
   endtask : heat
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   initial begin
      RST_N = 1'b0;
      CH_REQ_ON = 8'h00;
      SENSE = '0;
      w(4);
      RST_N = 1'b1;
      w(4);
      chk(PROT_FLAGS | OL_FLAGS, 8'h00);
      CH_REQ_ON = 8'hdf;
      w(3);
      chk(CH_ON, 8'hdf);
      heat;
      chk(CH_ON, 8'hd7);
      chk(PROT_FLAGS, 8'h08);
      SENSE.over_load[0] = 1'b1;
      w(20);
      SENSE.over_load[0] = 1'b0;
      chk(CH_ON, 8'hd6);
      chk(PROT_FLAGS, 8'h09);
      SENSE.open_load = 8'h60;
      w(10);
      chk(OL_FLAGS, 8'h00);
      w(20);
      SENSE.open_load = 8'h00;
      chk(OL_FLAGS, 8'h20);
      frame({1'b1, CTRL_DIAG_CUR_LO, 4'ha}, 8);
      frame({1'b1, CTRL_DIAG_CUR_HI, 4'h5}, 8);
      frame({1'b1, CTRL_DIAG_CUR_LO, 4'h0}, 5);
      chk(DIAG_CUR_EN, 8'h5a);
      frame({1'b1, CTRL_CMD, 4'h1}, 8);
      chk(PROT_FLAGS, 8'h00);
      chk(OL_FLAGS, 8'h20);
      chk(CH_ON, 8'hdf);
      frame({2'h0, DIAG_FLAGS_CH_4_5, 4'h1}, 8);
      frame(8'h02, 8);
      chk({4'h0, host.rx[3:0]}, 8'h08);
      chk({7'h0, SO_OE}, 8'h00);
      chk(OL_FLAGS, 8'h00);
      heat;
      chk(PROT_FLAGS, 8'h08);
      test_done;
   end
endmodule : test_channel_fault_diagnosis_latches
